/* File: rtl/analog_scaler_pkg.sv */
// package of constants for the analog value scaler
// assumes one clock domain and a converter that hands over unsigned codes
package analog_scaler_pkg;
  // ****************************************
  // widths
  // ****************************************
  localparam int unsigned CODE_W   = 12;
  localparam int unsigned RAW_W    = 10;
  localparam int unsigned GAIN_W   = 11;
  localparam int unsigned OFFSET_W = 15;
  localparam int unsigned END_W    = 16;
  localparam int unsigned VALUE_W  = 16;
  localparam int unsigned PROD_W   = 24;
  // ****************************************
  // ranges and scale
  // ****************************************
  localparam logic [CODE_W-1:0]          RAW_FULL_SCALE = 12'h3e8;
  localparam logic signed [GAIN_W-1:0]   GAIN_MAX       = 11'sh3e8;
  localparam logic signed [GAIN_W-1:0]   GAIN_MIN       = -11'sh3e8;
  localparam logic signed [OFFSET_W-1:0] OFFSET_MAX     = 15'sh2710;
  localparam logic signed [OFFSET_W-1:0] OFFSET_MIN     = -15'sh2710;
  localparam logic signed [PROD_W-1:0]   GAIN_DIVISOR   = 24'sh64;
  localparam logic signed [PROD_W-1:0]   SPAN_DIVISOR   = 24'sha;
  // ****************************************
  // reset values
  // ****************************************
  localparam logic signed [GAIN_W-1:0]   GAIN_RESET   = 11'sh064;
  localparam logic signed [OFFSET_W-1:0] OFFSET_RESET = 15'sh0000;
  localparam logic signed [VALUE_W-1:0]  VALUE_RESET  = 16'sh0000;
endpackage

/* File: rtl/scale_multiplier.sv */
// signed multiply and truncating division for the scaler
// assumes operands already clamped; result registered one cycle later
module scale_multiplier
  import analog_scaler_pkg::*;
(
  input  wire logic                       clk,
  input  wire logic                       reset,
  input  wire logic                       start,
  input  wire logic [RAW_W-1:0]           raw,
  input  wire logic signed [GAIN_W-1:0]   gain,
  input  wire logic signed [OFFSET_W-1:0] offset,
  output logic                            done,
  output logic signed [VALUE_W-1:0]       result
);
  import analog_scaler_pkg::*;

  logic signed [PROD_W-1:0] product;
  logic signed [PROD_W-1:0] sum;

  // ****************************************
  // arithmetic
  // ****************************************
  // division rounds toward zero, so fractions are dropped
  always_comb
  begin
    product = ($signed({1'b0, raw}) * gain) / GAIN_DIVISOR;
    sum     = product + PROD_W'(offset);
  end

  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      result <= VALUE_RESET;
      done   <= 1'b0;
    end
    else
    begin
      done <= start;
      if (start)
        result <= sum[VALUE_W-1:0];
    end
  end
endmodule

/* File: rtl/analog_value_scaler.sv */
// analog value scaler: raw converter code times gain plus offset
// assumes converter code and parameters are synchronous to clk
// Operation
// - each sample is held as an unsigned raw value from 0 to 1000.
// - any code above full scale saturates the raw value at 1000.
// - the actual value is raw times gain with the offset added.
// - gain is signed in hundredths and limited to -10.00 to +10.00.
// - offset is a signed integer limited to -10000 to +10000.
// - from low and high end values, offset is low and gain is (high-low)/1000.
module analog_value_scaler
  import analog_scaler_pkg::*;
(
  input  wire logic                          clk,
  input  wire logic                          reset,
  input  wire logic                          sample_valid,
  input  wire logic [analog_scaler_pkg::CODE_W-1:0] analog_input_channel,
  input  wire logic                          param_load,
  input  wire logic                          ends_mode,
  input  wire logic signed [analog_scaler_pkg::GAIN_W-1:0]   gain_in,
  input  wire logic signed [analog_scaler_pkg::OFFSET_W-1:0] offset_in,
  input  wire logic signed [analog_scaler_pkg::END_W-1:0]    low_end,
  input  wire logic signed [analog_scaler_pkg::END_W-1:0]    high_end,
  output logic                               value_valid,
  output logic signed [analog_scaler_pkg::VALUE_W-1:0] scaled_actual_value,
  output logic [analog_scaler_pkg::RAW_W-1:0]          raw_value,
  output logic signed [analog_scaler_pkg::GAIN_W-1:0]  gain,
  output logic signed [analog_scaler_pkg::OFFSET_W-1:0] offset
);
  import analog_scaler_pkg::*;

  logic                          start;
  logic signed [GAIN_W-1:0]      next_gain;
  logic signed [OFFSET_W-1:0]    next_offset;

  // ****************************************
  // helpers
  // ****************************************
  function automatic logic signed [GAIN_W-1:0] clamp_gain(input logic signed [PROD_W-1:0] g);
    if (g > PROD_W'(GAIN_MAX))
      return GAIN_MAX;
    else if (g < PROD_W'(GAIN_MIN))
      return GAIN_MIN;
    else
      return g[GAIN_W-1:0];
  endfunction

  function automatic logic signed [OFFSET_W-1:0] clamp_offset(input logic signed [PROD_W-1:0] o);
    if (o > PROD_W'(OFFSET_MAX))
      return OFFSET_MAX;
    else if (o < PROD_W'(OFFSET_MIN))
      return OFFSET_MIN;
    else
      return o[OFFSET_W-1:0];
  endfunction

  // ****************************************
  // parameter selection
  // ****************************************
  // span/1000 in hundredths is span/10; out-of-range entries clamp
  always_comb
  begin
    if (ends_mode)
    begin
      next_offset = clamp_offset(PROD_W'(low_end));
      next_gain   = clamp_gain((PROD_W'(high_end) - PROD_W'(low_end)) / SPAN_DIVISOR);
    end
    else
    begin
      next_offset = clamp_offset(PROD_W'(offset_in));
      next_gain   = clamp_gain(PROD_W'(gain_in));
    end
  end

  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      gain   <= GAIN_RESET;
      offset <= OFFSET_RESET;
    end
    else if (param_load)
    begin
      gain   <= next_gain;
      offset <= next_offset;
    end
  end

  // ****************************************
  // raw capture
  // ****************************************
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      raw_value <= '0;
      start     <= 1'b0;
    end
    else
    begin
      start <= sample_valid;
      if (sample_valid)
      begin
        if (analog_input_channel > RAW_FULL_SCALE)
          raw_value <= RAW_FULL_SCALE[RAW_W-1:0];
        else
          raw_value <= analog_input_channel[RAW_W-1:0];
      end
    end
  end

  // ****************************************
  // datapath
  // ****************************************
  scale_multiplier u_mult
  (
    .clk    (clk),
    .reset  (reset),
    .start  (start),
    .raw    (raw_value),
    .gain   (gain),
    .offset (offset),
    .done   (value_valid),
    .result (scaled_actual_value)
  );

  // ****************************************
  // checks
  // ****************************************
  property p_raw_range;
    @(posedge clk) disable iff (reset) raw_value <= RAW_FULL_SCALE[RAW_W-1:0];
  endproperty
  a_raw_range: assert property (p_raw_range) else $error("raw value above full scale");

  property p_saturate;
    @(posedge clk) disable iff (reset)
      sample_valid && analog_input_channel > RAW_FULL_SCALE |=> raw_value == RAW_FULL_SCALE[RAW_W-1:0];
  endproperty
  a_saturate: assert property (p_saturate) else $error("raw value not saturated");

  property p_gain_range;
    @(posedge clk) disable iff (reset) gain <= GAIN_MAX && gain >= GAIN_MIN;
  endproperty
  a_gain_range: assert property (p_gain_range) else $error("gain out of range");

  property p_offset_range;
    @(posedge clk) disable iff (reset) offset <= OFFSET_MAX && offset >= OFFSET_MIN;
  endproperty
  a_offset_range: assert property (p_offset_range) else $error("offset out of range");

  property p_ends_offset;
    @(posedge clk) disable iff (reset)
      param_load && ends_mode && low_end >= -16'sd10000 && low_end <= 16'sd10000 |=> offset == $past(low_end);
  endproperty
  a_ends_offset: assert property (p_ends_offset) else $error("offset not taken from low end");

  property p_latency;
    @(posedge clk) disable iff (reset) sample_valid |-> ##2 value_valid;
  endproperty
  a_latency: assert property (p_latency) else $error("result not two cycles after sample");

  property p_formula;
    @(posedge clk) disable iff (reset)
      start && !param_load |=> scaled_actual_value ==
        VALUE_W'(($signed({1'b0, $past(raw_value)}) * $past(gain)) / 100 + $past(offset));
  endproperty
  a_formula: assert property (p_formula) else $error("scaled value mismatch");

  property p_truncate;
    @(posedge clk) disable iff (reset)
      start && raw_value == 10'd2 && gain == 11'sd10 && offset == 15'sd0 && !param_load
      |=> scaled_actual_value == 16'sd0;
  endproperty
  a_truncate: assert property (p_truncate) else $error("fraction not discarded");

  property p_raw_pass;
    @(posedge clk) disable iff (reset)
      sample_valid && analog_input_channel <= RAW_FULL_SCALE |=> raw_value == $past(analog_input_channel[RAW_W-1:0]);
  endproperty
  a_raw_pass: assert property (p_raw_pass) else $error("raw value not taken from code");

  property p_raw_hold;
    @(posedge clk) disable iff (reset)
      !sample_valid |=> $stable(raw_value);
  endproperty
  a_raw_hold: assert property (p_raw_hold) else $error("raw value changed without sample");

  property p_gain_load;
    @(posedge clk) disable iff (reset)
      param_load && !ends_mode && gain_in <= GAIN_MAX && gain_in >= GAIN_MIN |=> gain == $past(gain_in);
  endproperty
  a_gain_load: assert property (p_gain_load) else $error("gain not loaded");

  property p_gain_high;
    @(posedge clk) disable iff (reset)
      param_load && !ends_mode && gain_in > GAIN_MAX |=> gain == GAIN_MAX;
  endproperty
  a_gain_high: assert property (p_gain_high) else $error("gain not clamped high");

  property p_gain_low;
    @(posedge clk) disable iff (reset)
      param_load && !ends_mode && gain_in < GAIN_MIN |=> gain == GAIN_MIN;
  endproperty
  a_gain_low: assert property (p_gain_low) else $error("gain not clamped low");

  property p_offset_load;
    @(posedge clk) disable iff (reset)
      param_load && !ends_mode && offset_in <= OFFSET_MAX && offset_in >= OFFSET_MIN |=> offset == $past(offset_in);
  endproperty
  a_offset_load: assert property (p_offset_load) else $error("offset not loaded");

  property p_offset_high;
    @(posedge clk) disable iff (reset)
      param_load && !ends_mode && offset_in > OFFSET_MAX |=> offset == OFFSET_MAX;
  endproperty
  a_offset_high: assert property (p_offset_high) else $error("offset not clamped high");

  property p_offset_low;
    @(posedge clk) disable iff (reset)
      param_load && !ends_mode && offset_in < OFFSET_MIN |=> offset == OFFSET_MIN;
  endproperty
  a_offset_low: assert property (p_offset_low) else $error("offset not clamped low");

  // spans within +-10000 give gains inside the clamp limits
  property p_ends_gain;
    @(posedge clk) disable iff (reset)
      param_load && ends_mode && int'(high_end) - int'(low_end) <= 10000
        && int'(high_end) - int'(low_end) >= -10000
      |=> int'(gain) == (int'($past(high_end)) - int'($past(low_end))) / 10;
  endproperty
  a_ends_gain: assert property (p_ends_gain) else $error("gain not derived from span");

  property p_value_hold;
    @(posedge clk) disable iff (reset)
      !start |=> $stable(scaled_actual_value);
  endproperty
  a_value_hold: assert property (p_value_hold) else $error("scaled value changed without sample");
endmodule

/* File: bench/adc_source_model.sv */
// converter source model: hands raw codes to the scaler, one per cycle at most
// assumes the caller runs on clk; drives only at falling edges
module adc_source_model
(
  input  wire logic                               clk,
  output logic                                    sample_valid,
  output logic [analog_scaler_pkg::CODE_W-1:0]    analog_input_channel
);
  timeunit 1ns;
  timeprecision 100ps;
  import analog_scaler_pkg::*;
  initial
  begin
    sample_valid = 1'b0;
    analog_input_channel = '0;
  end
  // code is inverted outside a sample so a stale code never looks right
  task automatic send(input logic [CODE_W-1:0] code, input logic hold);
    @(negedge clk);
    sample_valid = 1'b1;
    analog_input_channel = code;
    @(posedge clk);
    if (!hold)
    begin
      @(negedge clk);
      sample_valid = 1'b0;
      analog_input_channel = ~code;
    end
  endtask
endmodule

/* File: bench/analog_value_scaler_bench.sv */
// bench for the analog value scaler: examples, limits, derived mode
// assumes outputs settle within 1 ns of the rising edge
module analog_value_scaler_bench;
  timeunit 1ns;
  timeprecision 100ps;
  import analog_scaler_pkg::*;
  logic                        clk = 1'b0;
  logic                        reset = 1'b1;
  logic                        sample_valid;
  logic [CODE_W-1:0]           analog_input_channel;
  logic                        param_load = 1'b0;
  logic                        ends_mode = 1'b0;
  logic signed [GAIN_W-1:0]    gain_in = '0;
  logic signed [OFFSET_W-1:0]  offset_in = '0;
  logic signed [END_W-1:0]     low_end = '0;
  logic signed [END_W-1:0]     high_end = '0;
  logic                        value_valid;
  logic signed [VALUE_W-1:0]   scaled_actual_value;
  logic [RAW_W-1:0]            raw_value;
  logic signed [GAIN_W-1:0]    gain;
  logic signed [OFFSET_W-1:0]  offset;
  int                          miscompares = 0;
  int                          cmp_count = 0;
  int                          cycles = 0;
  always #5 clk = ~clk;
  adc_source_model adc_source_model_i (.clk(clk), .sample_valid(sample_valid),
    .analog_input_channel(analog_input_channel));
  analog_value_scaler analog_value_scaler_i (.clk(clk), .reset(reset), .sample_valid(sample_valid),
    .analog_input_channel(analog_input_channel), .param_load(param_load), .ends_mode(ends_mode),
    .gain_in(gain_in), .offset_in(offset_in), .low_end(low_end), .high_end(high_end),
    .value_valid(value_valid), .scaled_actual_value(scaled_actual_value), .raw_value(raw_value),
    .gain(gain), .offset(offset));
  // ****
  // shared tasks
  // ****
  task automatic complete_run();
    if (miscompares == 0 && cmp_count > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic check(input logic signed [31:0] seen, input logic signed [31:0] expv);
    cmp_count++;
    if (seen !== expv)
    begin
      miscompares++;
      $display("[ERR] %0t seen %0d expected %0d", $time, seen, expv);
    end
  endtask
  task automatic load(input logic ends, input int g, input int o, input int lo, input int hi);
    @(negedge clk);
    param_load = 1'b1;
    ends_mode = ends;
    gain_in = g[GAIN_W-1:0];
    offset_in = o[OFFSET_W-1:0];
    low_end = lo[END_W-1:0];
    high_end = hi[END_W-1:0];
    @(negedge clk);
    param_load = 1'b0;
  endtask
  // send returns after the taking edge; the result launches on the next edge
  task automatic sample(input int code, input int expv);
    adc_source_model_i.send(code[CODE_W-1:0], 1'b0);
    @(posedge clk);
    #1;
    check(value_valid, 1);
    check(scaled_actual_value, expv);
  endtask
  // ****
  // scenarios
  // ****
  task automatic t_table();
    int rw[8] = '{300, 675, 500, 1000, 500, 2, 2, 999};
    int gn[8] = '{10, 400, 1, 1000, 100, 10, 1000, -7};
    int of[8] = '{-30, 1000, 5, -10000, -200, 0, 0, 3};
    check(gain, 100);
    check(offset, 0);
    foreach (rw[i])
    begin
      load(1'b0, gn[i], of[i], 0, 0);
      sample(rw[i], rw[i] * gn[i] / 100 + of[i]);
      check(raw_value, rw[i]);
    end
  endtask
  task automatic t_limits();
    load(1'b0, 100, 0, 0, 0);
    sample(4095, 1000);
    check(raw_value, 1000);
    sample(1001, 1000);
    load(1'b0, 1023, 12000, 0, 0);
    check(gain, 1000);
    check(offset, 10000);
    load(1'b0, -1024, -16384, 0, 0);
    check(gain, -1000);
    check(offset, -10000);
    sample(1000, -20000);
  endtask
  task automatic t_derived();
    load(1'b1, 0, 0, -30, 70);
    check(gain, 10);
    check(offset, -30);
    sample(300, 0);
    load(1'b1, 0, 0, 1000, 5000);
    check(gain, 400);
    check(offset, 1000);
    sample(675, 3700);
    load(1'b1, 0, 0, -20000, 20000);
    check(gain, 1000);
    check(offset, -10000);
    sample(1000, 0);
  endtask
  task automatic t_back_to_back();
    load(1'b0, 100, 0, 0, 0);
    adc_source_model_i.send(12'h064, 1'b1);
    adc_source_model_i.send(12'h0c8, 1'b0);
    check(value_valid, 1);
    check(scaled_actual_value, 100);
    @(posedge clk);
    #1;
    check(value_valid, 1);
    check(scaled_actual_value, 200);
  endtask
  // mid-run reset must restore defaults, not keep the last load
  task automatic t_reset();
    load(1'b0, 250, 77, 0, 0);
    @(negedge clk);
    reset = 1'b1;
    repeat (2) @(negedge clk);
    reset = 1'b0;
    check(gain, 100);
    check(offset, 0);
    check(raw_value, 0);
    check(scaled_actual_value, 0);
    check(value_valid, 0);
    sample(500, 500);
  endtask
  // ****
  // run control
  // ****
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 3000)
    begin
      miscompares++;
      complete_run();
    end
  end
  initial
  begin
    repeat (5) @(negedge clk);
    reset = 1'b0;
    t_table();
    t_limits();
    t_derived();
    t_back_to_back();
    t_reset();
    complete_run();
  end
endmodule
